// file: rt_command_classifier.sv
// Contract
// - word valid only with good sync, Manchester, bit count, odd parity
// - sync selects command or data; command keeps only 16 data bits
// - command splits into address, direction, subaddress, count/mode fields
// - address equal to latched terminal address means individually addressed
// - address 31 is broadcast to all terminals
// - broadcast-invalid set: address 31 commands dropped silently
// - subaddress 1..30 is subaddress command; direction picks receive/transmit
// - subaddress word count from field, zero means 32 words
// - subaddress 0 or 31 is mode command; low bits are mode code
// - mode codes 16..31 carry exactly one data word
// - mode codes 0..15 carry no data; direction 0 is undefined
// - undefined: 0-15,16,18,19 with dir 0; 17,20,21 with dir 1
// - undefined-mode-invalid set: undefined modes dropped, no status update
// - undefined-mode-invalid resets to 0; table then decides response
// - undefined mode, table bit 0: clear status, data word for codes 16..21, status update
// - table bit 1: message error status only, no data, status update
// - reserved: 9-15 dir 1, 22-31 any dir; table decides
// - after master reset every table location reads zero
// - separate transmit/receive descriptor blocks select buffering method
// - mode data words use fixed per-code addresses, no pointers
// - valid command with descriptor interrupt enabled raises accessed flag
// - pending bits 2..0 ignore writes and read zero
// - one table bit per valid command from 256 words at 0x0200
`timescale 1ns/1ps
`default_nettype none

module rt_command_classifier
  import rt_cmd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        master_reset_n,
  input  wire rx_word_t    rx_word,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic      [15:0] ram_addr,
  output logic             ram_rd,
  output logic             ram_wr,
  output logic      [15:0] ram_wdata,
  input  wire logic [15:0] ram_rdata,
  output resp_t            resp,
  output logic             accessed_interrupt_flag,
  output logic             table_clear_busy
);

  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_IDLE,
    ST_ILL,
    ST_ILL_D,
    ST_DESC,
    ST_DESC_D
  } state_t;

  state_t      state_r;
  state_t      state_nxt;
  logic        mr_s1_r;
  logic        mr_s2_r;
  logic [7:0]  clr_idx_r;
  logic [7:0]  clr_idx_nxt;
  logic [1:0]  cfg_r;
  logic [4:0]  taddr_r;
  logic        pend_r;
  logic        pend_nxt;
  cmd_word_t   cmd_r;
  cmd_word_t   last_cmd_r;
  logic        bcast_r;
  logic        undef_r;
  logic        rsv_r;
  logic        illegal_r;
  logic [15:0] ram_addr_nxt;
  resp_t       resp_nxt;
  resp_kind_t  last_kind_r;
  logic [15:0] rdata_nxt;

  // master reset pin, two-stage synchroniser
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mr_s1_r <= 1'b1;
      mr_s2_r <= 1'b1;
    end else begin
      mr_s1_r <= master_reset_n;
      mr_s2_r <= mr_s1_r;
    end
  end

  wire soft_rst = ~mr_s2_r;

  // incoming word checks
  wire       rx_parity_ok = ^{rx_word.data, rx_word.parity};
  wire       rx_valid     = rx_word.strobe & rx_word.sync_ok &
                            rx_word.manch_ok & rx_word.bits_ok &
                            rx_parity_ok;
  wire       rx_cmd       = rx_valid & rx_word.cmd_sync;
  cmd_word_t rx_fields;
  assign rx_fields = cmd_word_t'(rx_word.data);

  // addressing
  wire bcst_inv  = cfg_r[CFG_BCST_INV];
  wire umc_inv   = cfg_r[CFG_UMC_INV];
  wire to_bcast  = (rx_fields.taddr == BCAST_TADDR);
  wire is_indiv  = ~to_bcast & (rx_fields.taddr == taddr_r);
  wire is_bcast  = to_bcast & ~bcst_inv;

  // command type
  wire       is_mode = (rx_fields.sa == SA_MODE_LO) |
                       (rx_fields.sa == SA_MODE_HI);
  wire [4:0] mc      = rx_fields.wc;
  wire       tr      = rx_fields.tr;
  wire       mc_data = (mc >= MC_DATA_MIN);

  wire undef_rx0 = ~tr & (~mc_data | (mc == MC_16) |
                   (mc == MC_18) | (mc == MC_19));
  wire undef_tx1 = tr & ((mc == MC_17) | (mc == MC_20) |
                   (mc == MC_21));
  wire is_undef  = is_mode & (undef_rx0 | undef_tx1);
  wire is_rsv    = is_mode & ((tr & (mc >= MC_RSV_TX_LO) &
                   ~mc_data) | (mc >= MC_RSV_LO));

  // broadcast transmit to a subaddress has no defined response
  wire bcast_tx_sa = is_bcast & tr & ~is_mode;

  wire accept = rx_cmd & (is_indiv | is_bcast) & ~bcast_tx_sa &
                ~(is_undef & umc_inv);

  // table word index: broadcast, direction, subaddress, upper half
  wire [7:0]  ill_idx  = {bcast_r, cmd_r.tr, cmd_r.sa,
                          cmd_r.wc[4]};
  wire [15:0] ill_addr = ILL_BASE + {8'h00, ill_idx};
  wire        ill_bit  = ram_rdata[cmd_r.wc[3:0]];

  // descriptor blocks: direction, kind, subaddress or mode code
  wire        cmd_mode  = (cmd_r.sa == SA_MODE_LO) |
                          (cmd_r.sa == SA_MODE_HI);
  wire [4:0]  desc_fld  = cmd_mode ? cmd_r.wc : cmd_r.sa;
  wire [6:0]  desc_idx  = {cmd_r.tr, cmd_mode, desc_fld};
  wire [15:0] desc_addr = DESC_BASE + {7'h00, desc_idx, 2'h0};
  wire [15:0] clr_addr  = ILL_BASE + {8'h00, clr_idx_r};

  // data word count and location
  wire        cmd_mdata = cmd_mode & (cmd_r.wc >= MC_DATA_MIN);
  wire [5:0]  sa_words  = (cmd_r.wc == 5'h00) ? WC_ZERO_WORDS
                          : {1'b0, cmd_r.wc};
  wire [5:0]  inf_words = cmd_mode ? (cmd_mdata ? MODE_DATA_WORDS
                          : 6'h00) : sa_words;
  wire [15:0] mode_addr = MODE_DATA_BASE +
                          {10'h000, bcast_r, cmd_r.tr, cmd_r.wc[3:0]};
  wire [15:0] ptr_addr  = desc_addr + 16'h0001;
  wire [15:0] data_loc  = cmd_mdata ? mode_addr
                          : (cmd_mode ? 16'h0000 : ptr_addr);

  // next state
  always_comb begin
    state_nxt   = state_r;
    clr_idx_nxt = clr_idx_r;
    unique case (state_r)
      ST_CLEAR: begin
        clr_idx_nxt = clr_idx_r + 8'h01;
        if (clr_idx_r == ILL_LAST[7:0]) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_ILL;
        end
      end
      ST_ILL: begin
        state_nxt = ST_ILL_D;
      end
      ST_ILL_D: begin
        state_nxt = ST_DESC;
      end
      ST_DESC: begin
        state_nxt = ST_DESC_D;
      end
      ST_DESC_D: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (soft_rst) begin
      state_nxt   = ST_CLEAR;
      clr_idx_nxt = 8'h00;
    end
  end

  // ram port
  always_comb begin
    ram_addr_nxt = 16'h0000;
    unique case (state_nxt)
      ST_CLEAR: ram_addr_nxt = (state_r == ST_CLEAR && !soft_rst) ?
                               ILL_BASE + {8'h00, clr_idx_nxt} : ILL_BASE;
      ST_ILL:   ram_addr_nxt = ILL_BASE;
      ST_DESC:  ram_addr_nxt = desc_addr;
      default:  ram_addr_nxt = 16'h0000;
    endcase
  end

  // table address depends on latched command, so issue it one cycle on
  wire [15:0] ram_addr_sel = (state_r == ST_ILL) ? ill_addr : ram_addr_nxt;

  // response build
  always_comb begin
    resp_nxt               = '0;
    resp_nxt.kind          = RESP_NONE;
    if (state_r == ST_DESC_D) begin
      resp_nxt.valid         = 1'b1;
      resp_nxt.kind          = illegal_r ? RESP_MSG_ERR
                               : RESP_IN_FORM;
      resp_nxt.bcast         = bcast_r;
      resp_nxt.mode          = cmd_mode;
      resp_nxt.tr            = cmd_r.tr;
      resp_nxt.field         = cmd_r.wc;
      resp_nxt.words         = illegal_r ? 6'h00 : inf_words;
      resp_nxt.buf_method    = cmd_mode ? 2'h0
                               : ram_rdata[DESC_BUF_LSB +: 2];
      resp_nxt.data_addr     = data_loc;
      resp_nxt.undefined     = undef_r;
      resp_nxt.reserved      = rsv_r;
      resp_nxt.update_status = 1'b1;
    end
  end

  wire iwa_set = (state_r == ST_DESC_D) &
                 ram_rdata[DESC_IWA_BIT];

  // register decode
  wire wr_cfg   = reg_wr & (reg_addr == REG_CFG);
  wire wr_taddr = reg_wr & (reg_addr == REG_TADDR);
  wire wr_pend  = reg_wr & (reg_addr == REG_PEND);

  // write one clears; a new event in the same cycle wins
  assign pend_nxt = (pend_r & ~(wr_pend & reg_wdata[PEND_ACC_BIT])) |
                    iwa_set;

  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (reg_addr)
      REG_CFG:      rdata_nxt = {14'h0000, cfg_r};
      REG_TADDR:    rdata_nxt = {11'h000, taddr_r};
      REG_PEND:     rdata_nxt = {12'h000, pend_r, 3'h0};
      REG_LAST_CMD: rdata_nxt = last_cmd_r;
      REG_CLASS:    rdata_nxt = {10'h000, table_clear_busy,
                                 rsv_r, undef_r, bcast_r,
                                 last_kind_r};
      default:      rdata_nxt = 16'h0000;
    endcase
  end

  // control state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r   <= ST_CLEAR;
      clr_idx_r <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      clr_idx_r <= clr_idx_nxt;
    end
  end

  // configuration
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_r   <= CFG_RST;
      taddr_r <= TADDR_RST;
      pend_r  <= 1'b0;
    end else if (soft_rst) begin
      cfg_r   <= CFG_RST;
      taddr_r <= TADDR_RST;
      pend_r  <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= reg_wdata[1:0];
      end
      if (wr_taddr) begin
        taddr_r <= reg_wdata[4:0];
      end
      pend_r <= pend_nxt;
    end
  end

  // captured command and its class
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_r   <= '0;
      bcast_r <= 1'b0;
      undef_r <= 1'b0;
      rsv_r   <= 1'b0;
    end else if (state_r == ST_IDLE && accept) begin
      cmd_r   <= rx_fields;
      bcast_r <= is_bcast;
      undef_r <= is_undef;
      rsv_r   <= is_rsv;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      illegal_r <= 1'b0;
    end else if (state_r == ST_DESC) begin
      // table word stands on the ram data lines only in this cycle
      illegal_r <= ill_bit;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      last_cmd_r  <= '0;
      last_kind_r <= RESP_NONE;
    end else if (resp_nxt.valid) begin
      last_cmd_r  <= cmd_r;
      last_kind_r <= resp_nxt.kind;
    end
  end

  // registered outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ram_addr                <= 16'h0000;
      ram_rd                  <= 1'b0;
      ram_wr                  <= 1'b0;
      ram_wdata               <= 16'h0000;
      resp                    <= '0;
      reg_rdata               <= 16'h0000;
      accessed_interrupt_flag <= 1'b0;
      table_clear_busy        <= 1'b1;
    end else begin
      // clear write follows the walk index of this cycle, so 0x0200 is included
      ram_addr                <= (state_r == ST_CLEAR) ? clr_addr
                                 : (state_nxt == ST_ILL_D) ? ill_addr
                                 : ram_addr_sel;
      ram_rd                  <= (state_nxt == ST_ILL_D) |
                                 (state_nxt == ST_DESC);
      ram_wr                  <= (state_r == ST_CLEAR);
      ram_wdata               <= 16'h0000;
      resp                    <= resp_nxt;
      reg_rdata               <= reg_rd ? rdata_nxt : 16'h0000;
      accessed_interrupt_flag <= pend_nxt;
      table_clear_busy        <= (state_nxt == ST_CLEAR);
    end
  end

endmodule

`default_nettype wire

// file: rt_cmd_pkg.sv
package rt_cmd_pkg;

  // word and field layout
  localparam int          DATA_W          = 16;
  localparam int          FIELD_W         = 5;
  localparam logic [4:0]  BCAST_TADDR     = 5'h1f;
  localparam logic [4:0]  SA_MODE_LO      = 5'h00;
  localparam logic [4:0]  SA_MODE_HI      = 5'h1f;
  localparam logic [4:0]  MC_DATA_MIN     = 5'h10;
  localparam logic [4:0]  MC_RSV_TX_LO    = 5'h09;
  localparam logic [4:0]  MC_RSV_LO       = 5'h16;
  localparam logic [4:0]  MC_16           = 5'h10;
  localparam logic [4:0]  MC_17           = 5'h11;
  localparam logic [4:0]  MC_18           = 5'h12;
  localparam logic [4:0]  MC_19           = 5'h13;
  localparam logic [4:0]  MC_20           = 5'h14;
  localparam logic [4:0]  MC_21           = 5'h15;
  localparam logic [5:0]  WC_ZERO_WORDS   = 6'h20;
  localparam logic [5:0]  MODE_DATA_WORDS = 6'h01;

  // shared ram map
  localparam logic [15:0] ILL_BASE        = 16'h0200;
  localparam logic [15:0] ILL_LAST        = 16'h02ff;
  localparam logic [15:0] DESC_BASE       = 16'h0400;
  localparam logic [15:0] MODE_DATA_BASE  = 16'h0600;
  localparam int          DESC_IWA_BIT    = 15;
  localparam int          DESC_BUF_LSB    = 0;

  // register port map, byte addresses
  localparam logic [7:0]  REG_CFG         = 8'h00;
  localparam logic [7:0]  REG_TADDR       = 8'h04;
  localparam logic [7:0]  REG_PEND        = 8'h08;
  localparam logic [7:0]  REG_LAST_CMD    = 8'h0c;
  localparam logic [7:0]  REG_CLASS       = 8'h10;
  localparam int          CFG_BCST_INV    = 0;
  localparam int          CFG_UMC_INV     = 1;
  localparam int          PEND_ACC_BIT    = 3;
  localparam logic [1:0]  CFG_RST         = 2'h0;
  localparam logic [4:0]  TADDR_RST       = 5'h00;

  typedef struct packed {
    logic [4:0] taddr;
    logic       tr;
    logic [4:0] sa;
    logic [4:0] wc;
  } cmd_word_t;

  typedef struct packed {
    logic        strobe;
    logic        cmd_sync;
    logic        sync_ok;
    logic        manch_ok;
    logic        bits_ok;
    logic [15:0] data;
    logic        parity;
  } rx_word_t;

  typedef enum logic [1:0] {
    RESP_NONE,
    RESP_IN_FORM,
    RESP_MSG_ERR
  } resp_kind_t;

  typedef struct packed {
    logic        valid;
    resp_kind_t  kind;
    logic        bcast;
    logic        mode;
    logic        tr;
    logic [4:0]  field;
    logic [5:0]  words;
    logic [1:0]  buf_method;
    logic [15:0] data_addr;
    logic        undefined;
    logic        reserved;
    logic        update_status;
  } resp_t;

endpackage

// file: rt_shared_ram.sv
`timescale 1ns/1ps
`default_nettype none

module rt_shared_ram (
  input  wire logic        mclk,
  input  wire logic [15:0] ram_addr,
  input  wire logic        ram_rd,
  input  wire logic        ram_wr,
  input  wire logic [15:0] ram_wdata,
  output logic      [15:0] ram_rdata
);
  logic [15:0] mem [0:4095];

  // table starts dirty so the clear walk shows
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = (i >= 16'h0200 && i <= 16'h02ff) ? 16'hffff : 16'h0000;
    end
    ram_rdata = 16'h0000;
  end

  // data only in the cycle after a read, else toggles
  always @(posedge mclk) begin
    if (ram_wr) begin
      mem[ram_addr[11:0]] <= ram_wdata;
    end
    if (ram_rd) begin
      ram_rdata <= mem[ram_addr[11:0]];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule

`default_nettype wire

// file: rt_command_classifier_chk.sv
`timescale 1ns/1ps
`default_nettype none

module rt_command_classifier_chk
  import rt_cmd_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        master_reset_n,
  input wire rx_word_t    rx_word,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] ram_addr,
  input wire logic        ram_rd,
  input wire logic        ram_wr,
  input wire logic [15:0] ram_wdata,
  input wire logic [15:0] ram_rdata,
  input wire resp_t       resp,
  input wire logic        accessed_interrupt_flag,
  input wire logic        table_clear_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  AST_BAD_WORD: assert property (rx_word.strobe && !(rx_word.sync_ok && rx_word.manch_ok
    && rx_word.bits_ok && ^{rx_word.data, rx_word.parity}) |-> ##5 !resp.valid)
    else $error("bad word answered");
  AST_DATA_WORD: assert property (rx_word.strobe && !rx_word.cmd_sync |-> ##5 !resp.valid)
    else $error("data word answered");
  AST_BCAST: assert property (resp.valid && resp.bcast |->
    $past(rx_word.data[15:11], 5) == BCAST_TADDR) else $error("broadcast flag wrong");
  AST_MODE_SPLIT: assert property (resp.valid |-> resp.mode ==
    ($past(rx_word.data[9:5], 5) == SA_MODE_LO || $past(rx_word.data[9:5], 5) == SA_MODE_HI))
    else $error("mode split wrong");
  AST_WC_ZERO: assert property (resp.valid && resp.kind == RESP_IN_FORM && !resp.mode |->
    resp.words == (resp.field == 5'h00 ? WC_ZERO_WORDS : {1'b0, resp.field}))
    else $error("word count wrong");
  AST_MODE_WORDS: assert property (resp.valid && resp.kind == RESP_IN_FORM && resp.mode |->
    resp.words == (resp.field >= MC_DATA_MIN ? MODE_DATA_WORDS : 6'h00))
    else $error("mode word count wrong");
  AST_MSG_ERR: assert property (resp.valid && resp.kind == RESP_MSG_ERR |->
    resp.words == 6'h00 && resp.update_status) else $error("message error carries data");
  AST_UNDEF: assert property (resp.valid && resp.mode |-> resp.undefined ==
    ((!resp.tr && resp.field <= MC_19 && resp.field != MC_17)
    || (resp.tr && (resp.field == MC_17 || resp.field == MC_20 || resp.field == MC_21))))
    else $error("undefined flag wrong");
  AST_RSV: assert property (resp.valid && resp.mode |-> resp.reserved ==
    ((resp.tr && resp.field >= MC_RSV_TX_LO && resp.field < MC_16) || resp.field >= MC_RSV_LO))
    else $error("reserved flag wrong");
  AST_MODE_ADDR: assert property (resp.valid && resp.mode && resp.field >= MC_DATA_MIN |->
    resp.data_addr == MODE_DATA_BASE + {resp.bcast, resp.tr, resp.field[3:0]})
    else $error("mode data address wrong");
  AST_PEND_LOW: assert property (reg_rd && reg_addr == REG_PEND |=> reg_rdata[2:0] == 3'h0)
    else $error("pending low bits set");
  AST_CLEAR: assert property (ram_wr |-> ram_wdata == 16'h0000
    && ram_addr >= ILL_BASE && ram_addr <= ILL_LAST) else $error("clear write wrong");
  AST_FETCH: assert property (resp.valid |-> $past(ram_rd, 3)
    && $past(ram_addr, 3) >= ILL_BASE && $past(ram_addr, 3) <= ILL_LAST)
    else $error("table fetch missing");
  AST_IWA: assert property ($rose(accessed_interrupt_flag) |-> resp.valid)
    else $error("flag rose without command");
endmodule

`default_nettype wire

// file: rt_command_classifier_test.sv
`timescale 1ns/1ps
`default_nettype none

module rt_command_classifier_test
  import rt_cmd_pkg::*;
;
  logic        mclk = 1'b0, reset = 1'b1, master_reset_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  rx_word_t    rx_word = '0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, ram_addr, ram_wdata, ram_rdata;
  logic        ram_rd, ram_wr, accessed_interrupt_flag, table_clear_busy;
  resp_t       resp, r;
  int          fails = 0, total_checks = 0;

  always #5 mclk = ~mclk;

  rt_command_classifier rt_command_classifier_inst (.mclk(mclk), .reset(reset),
    .master_reset_n(master_reset_n), .rx_word(rx_word), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .resp(resp), .accessed_interrupt_flag(accessed_interrupt_flag),
    .table_clear_busy(table_clear_busy));
  rt_shared_ram rt_shared_ram_inst (.mclk(mclk), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task reg_read(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // b: sync, manchester, bit count, parity faults
  task cmd(input logic [15:0] d, input logic [3:0] b, input logic ds, input logic ev,
           input resp_kind_t ek, input logic [5:0] ew);
    @(posedge mclk);
    rx_word <= '{1'b1, !ds, !b[0], !b[1], !b[2], d, (~^d) ^ b[3]};
    @(posedge mclk);
    rx_word.strobe <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 r = resp;
    chk(r.valid, ev);
    if (ev) begin
      chk(r.kind, ek);
      chk(r.words, ew);
    end
  endtask

  task wait_clear;
    int n;
    n = 0;
    while (table_clear_busy !== 1'b0 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(table_clear_busy, 1'b0);
    // last clear write lands one edge after busy falls
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task t_reset;
    wait_clear();
    for (int i = 0; i < 256; i++) chk(rt_shared_ram_inst.mem[12'h200 + i], 16'h0000);
    reg_read(REG_CFG, 16'h0000);
    reg_read(REG_TADDR, 16'h0000);
  endtask

  task t_address;
    reg_write(REG_TADDR, 16'h0005);
    cmd({5'd5, 1'b0, 5'd1, 5'd0}, 4'h0, 1'b0, 1'b1, RESP_IN_FORM, 6'h20);
    cmd({5'd5, 1'b1, 5'd30, 5'd7}, 4'h0, 1'b0, 1'b1, RESP_IN_FORM, 6'h07);
    for (int i = 0; i < 4; i++) cmd({5'd5, 1'b0, 5'd1, 5'd2}, 4'h1 << i, 1'b0, 1'b0, RESP_NONE, 6'h00);
    cmd({5'd5, 1'b0, 5'd1, 5'd2}, 4'h0, 1'b1, 1'b0, RESP_NONE, 6'h00);
    cmd({5'd6, 1'b0, 5'd1, 5'd2}, 4'h0, 1'b0, 1'b0, RESP_NONE, 6'h00);
    cmd({5'd31, 1'b0, 5'd1, 5'd3}, 4'h0, 1'b0, 1'b1, RESP_IN_FORM, 6'h03);
    chk(r.bcast, 1'b1);
    reg_write(REG_CFG, 16'h0001);
    cmd({5'd31, 1'b0, 5'd1, 5'd3}, 4'h0, 1'b0, 1'b0, RESP_NONE, 6'h00);
  endtask

  task t_modes;
    logic       tr, un, rs;
    logic [4:0] mc;
    for (int u = 0; u < 2; u++) begin
      reg_write(REG_CFG, 16'(u << 1));
      for (int k = 0; k < 64; k++) begin
        tr = k[5];
        mc = k[4:0];
        un = (!tr && (mc <= 5'd19) && mc != 5'd17) || (tr && (mc == 5'd17 || mc == 5'd20 || mc == 5'd21));
        rs = (tr && mc >= 5'd9 && mc <= 5'd15) || mc >= 5'd22;
        cmd({5'd5, tr, tr ? 5'h1f : 5'h00, mc}, 4'h0, 1'b0, !(u == 1 && un),
            RESP_IN_FORM, (mc >= 5'd16) ? 6'h01 : 6'h00);
        if (!(u == 1 && un)) begin
          chk(r.mode, 1'b1);
          chk(r.undefined, un);
          chk(r.reserved, rs);
          chk(r.data_addr, (mc >= 5'd16) ? MODE_DATA_BASE + {tr, mc[3:0]} : 16'h0000);
        end
      end
    end
    reg_write(REG_CFG, 16'h0000);
  endtask

  task t_illegal;
    rt_shared_ram_inst.mem[12'h202] = 16'h0008;
    rt_shared_ram_inst.mem[12'h201] = 16'h0001;
    cmd({5'd5, 1'b0, 5'd1, 5'd3}, 4'h0, 1'b0, 1'b1, RESP_MSG_ERR, 6'h00);
    cmd({5'd5, 1'b0, 5'd1, 5'd4}, 4'h0, 1'b0, 1'b1, RESP_IN_FORM, 6'h04);
    cmd({5'd5, 1'b0, 5'd0, 5'd16}, 4'h0, 1'b0, 1'b1, RESP_MSG_ERR, 6'h00);
  endtask

  task t_accessed;
    rt_shared_ram_inst.mem[12'h404] = 16'h8002;
    cmd({5'd5, 1'b0, 5'd1, 5'd5}, 4'h0, 1'b0, 1'b1, RESP_IN_FORM, 6'h05);
    chk(r.buf_method, 2'h2);
    chk(accessed_interrupt_flag, 1'b1);
    reg_read(REG_LAST_CMD, 16'h2825);
    reg_read(REG_CLASS, 16'h0001);
    reg_read(REG_PEND, 16'h0008);
    reg_write(REG_PEND, 16'h000f);
    reg_read(REG_PEND, 16'h0000);
    chk(accessed_interrupt_flag, 1'b0);
  endtask

  task t_master_reset;
    reg_write(REG_CFG, 16'h0003);
    @(posedge mclk);
    master_reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    master_reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(table_clear_busy, 1'b1);
    wait_clear();
    chk(rt_shared_ram_inst.mem[12'h202], 16'h0000);
    reg_read(REG_CFG, 16'h0000);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_address();
    t_modes();
    t_illegal();
    t_accessed();
    t_master_reset();
    end_sim();
  end

  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule

bind rt_command_classifier rt_command_classifier_chk rt_command_classifier_chk_inst (
  .mclk(mclk), .reset(reset), .master_reset_n(master_reset_n), .rx_word(rx_word),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr),
  .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .resp(resp),
  .accessed_interrupt_flag(accessed_interrupt_flag), .table_clear_busy(table_clear_busy));

`default_nettype wire
